// ---- src/hdi_bus_if.sv ----
// Strobes and data from the processor pin front end to the register core
`timescale 1ns/1ps
`default_nettype none
interface hdi_bus_if;
  import hdi_pkg::*;
  logic              rd_start;
  logic              rd_end;
  logic              wr_strobe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  modport port (output rd_start, rd_end, wr_strobe, addr, wdata);
  modport core (input rd_start, rd_end, wr_strobe, addr, wdata);
endinterface
`default_nettype wire

// ---- src/hdi_bus_port.sv ----
// Pin synchroniser and strobe generator for the parallel processor bus
`timescale 1ns/1ps
`default_nettype none
module hdi_bus_port
  import hdi_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  // Processor pins, asynchronous to the clock
  input  wire logic              cs_n_in,
  input  wire logic              rd_n_in,
  input  wire logic              wr_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  // Strobes toward the core
  hdi_bus_if.port                bus
);

  localparam int unsigned PIN_W = 3 + ADDR_W + DATA_W;
  localparam logic [PIN_W-1:0] PIN_IDLE = {3'h7, {(ADDR_W + DATA_W){1'b0}}};

  logic [PIN_W-1:0]  meta_q;
  logic [PIN_W-1:0]  sync_q;
  logic              rd_act_q;
  logic              wr_act_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  wire               s_cs_n  = sync_q[PIN_W-1];
  wire               s_rd_n  = sync_q[PIN_W-2];
  wire               s_wr_n  = sync_q[PIN_W-3];
  wire [ADDR_W-1:0]  s_addr  = sync_q[DATA_W +: ADDR_W];
  wire [DATA_W-1:0]  s_data  = sync_q[DATA_W-1:0];
  wire               rd_act  = ~s_cs_n & ~s_rd_n;
  wire               wr_act  = ~s_cs_n & ~s_wr_n;

  // Two stages on every pin; only the second stage is read
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      meta_q <= PIN_IDLE;
      sync_q <= PIN_IDLE;
    end else if (ce_in) begin
      meta_q <= {cs_n_in, rd_n_in, wr_n_in, addr_in, data_in};
      sync_q <= meta_q;
    end
  end

  // Previous strobe levels; write data kept from the last active cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      addr_q   <= '0;
      wdata_q  <= '0;
    end else if (ce_in) begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act) begin
        addr_q  <= s_addr;
        wdata_q <= s_data;
      end
    end
  end

  // Write takes effect on the trailing edge, when data is surely settled
  assign bus.rd_start  = ce_in & rd_act & ~rd_act_q;
  assign bus.rd_end    = ce_in & ~rd_act & rd_act_q;
  assign bus.wr_strobe = ce_in & ~wr_act & wr_act_q;
  assign bus.addr      = bus.wr_strobe ? addr_q : s_addr;
  assign bus.wdata     = wdata_q;

endmodule
`default_nettype wire

// ---- src/hdi_idle_det.sv ----
// Counter of consecutive received ones for receiver idle detection
`timescale 1ns/1ps
`default_nettype none
module hdi_idle_det
  import hdi_pkg::*;
(
  // Clock, reset, enable
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  // Received bit stream
  input  wire logic rx_bit_valid_in,
  input  wire logic rx_bit_in,
  // One-cycle pulse when idle is entered
  output logic      idle_pulse_out
);

  logic [IDLE_CNT_W-1:0] ones_q;
  logic [IDLE_CNT_W-1:0] ones_d;
  wire                   at_limit = (ones_q == IDLE_ONES);

  // Saturate at the limit so one long idle run gives one event
  assign ones_d = !rx_bit_in ? '0 :
                  at_limit   ? ones_q :
                  IDLE_CNT_W'(ones_q + 1'b1);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ones_q         <= '0;
      idle_pulse_out <= 1'b0;
    end else if (ce_in) begin
      idle_pulse_out <= 1'b0;
      if (rx_bit_valid_in) begin
        ones_q         <= ones_d;
        idle_pulse_out <= rx_bit_in & (ones_d == IDLE_ONES) & ~at_limit;
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/hdi_irq_mask_status.sv ----
// Interrupt mask and status registers with interrupt pin of an HDLC controller
`timescale 1ns/1ps
`default_nettype none
module hdi_irq_mask_status
  import hdi_pkg::*;
#(
  parameter int unsigned FILL_WIDTH = FILL_W
) (
  // Clock, reset, enable
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  // Processor bus pins
  input  wire logic                  cs_n_in,
  input  wire logic                  rd_n_in,
  input  wire logic                  wr_n_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [DATA_W-1:0]     data_in,
  output logic      [DATA_W-1:0]     data_out,
  output logic                       data_oe_out,
  // Mode controls from the rest of the controller
  // Levels, same clock, not resampled
  input  wire logic                  level_status_mode_in,
  input  wire logic                  no_framing_mode_in,
  input  wire logic                  tx_reset_cmd_in,
  // Transmit engine events
  // Fill levels are plain binary counts
  input  wire logic                  tx_frame_end_in,
  input  wire logic                  underrun_abort_in,
  input  wire logic [FILL_WIDTH-1:0] tx_fill_in,
  input  wire logic [FILL_WIDTH-1:0] tx_empty_level_in,
  // Receive engine events
  // Event inputs are one-clock pulses
  input  wire logic                  rx_frame_end_in,
  input  wire logic                  rx_overflow_in,
  input  wire logic [FILL_WIDTH-1:0] rx_fill_in,
  input  wire logic [FILL_WIDTH-1:0] rx_full_level_in,
  input  wire logic                  rx_bit_valid_in,
  input  wire logic                  rx_bit_in,
  // Interrupt pin and controls toward the engines
  // Pin is active low, as on the board
  output logic                       irq_n_out,
  output logic                       tx_hold_out,
  output logic                       force_bad_fcs_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Front end and idle detector
  //
  // Pins are resampled twice before decode;
  // the cost is a few clocks per access.

  hdi_bus_if bus ();

  // Synchroniser and strobe generator
  hdi_bus_port u_bus_port (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .cs_n_in    (cs_n_in),
    .rd_n_in    (rd_n_in),
    .wr_n_in    (wr_n_in),
    .addr_in    (addr_in),
    .data_in    (data_in),
    .bus        (bus.port)
  );

  // One-clock pulse on entering idle
  logic idle_pulse;

  // Counts consecutive received ones
  hdi_idle_det u_idle_det (
    .ref_clk_in      (ref_clk_in),
    .rst_n_in        (rst_n_in),
    .ce_in           (ce_in),
    .rx_bit_valid_in (rx_bit_valid_in),
    .rx_bit_in       (rx_bit_in),
    .idle_pulse_out  (idle_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  // Enables and the test bit
  logic [DATA_W-1:0]     irq_mask_q;
  logic [DATA_W-1:0]     irq_mask_d;

  // Recorded event flags
  logic [NUM_EVENTS-1:0] irq_status_q;
  logic [NUM_EVENTS-1:0] irq_status_d;

  // Interrupt pin latch
  logic                  irq_active_q;
  logic                  irq_active_d;

  // Empty history for the raw-mode event
  logic                  tx_empty_q;

  // Read snapshot and driver enable
  logic [DATA_W-1:0]     rdata_q;
  logic                  oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  //
  // Only two indices live here; the rest
  // of the map is decoded elsewhere.

  wire hit_mask   = (bus.addr == REG_MASK_ADDR);
  wire hit_status = (bus.addr == REG_STATUS_ADDR);
  wire wr_mask    = bus.wr_strobe & hit_mask;

  // Status is read-to-clear; writes to it are dropped
  wire rd_status  = bus.rd_start & hit_status;
  // Mask reads have no side effect
  wire rd_mask    = bus.rd_start & hit_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Event conditions
  //
  // Engine inputs share this clock, so they
  // are used as they come, with no resampling.

  // Fill comparisons feed the level flags and the raw-mode done event
  wire tx_empty   = (tx_fill_in == FILL_WIDTH'(FILL_EMPTY));
  wire tx_low     = (tx_fill_in <= tx_empty_level_in);
  wire rx_high    = (rx_fill_in >= rx_full_level_in);
  // Framing-only events are gated once, here
  wire framed     = ~no_framing_mode_in;

  // Done comes from the frame end when framed, the FIFO draining otherwise
  wire set_done_framed = framed & tx_frame_end_in;
  wire set_done_raw    = no_framing_mode_in & tx_empty & ~tx_empty_q;
  // Transmitter reset restores the done default without framing
  wire set_done_reset  = no_framing_mode_in & tx_reset_cmd_in;
  wire set_done        = set_done_framed |
                         set_done_raw |
                         set_done_reset;

  // Underrun and frame end are framing events only
  // and simply vanish without framing
  wire set_underrun    = framed & underrun_abort_in;
  wire set_rx_end      = framed & rx_frame_end_in;
  // Overflow and idle flags set in any mode; the idle enable drops out without framing
  wire set_overflow    = rx_overflow_in;
  wire set_idle        = idle_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Status next values; a set in the clearing cycle wins

  // An event in the read edge is held over
  // for the next read, so none is lost;
  // the snapshot never shows it twice.
  always_comb begin
    irq_status_d = irq_status_q;
    // Transmit side
    irq_status_d[BIT_TX_DONE]     = hdi_sticky(irq_status_q[BIT_TX_DONE],
                                               set_done, rd_status);
    irq_status_d[BIT_TX_LOW]      = hdi_level_flag(level_status_mode_in,
                                                   irq_status_q[BIT_TX_LOW],
                                                   tx_low, rd_status);
    irq_status_d[BIT_UNDERRUN]    = hdi_sticky(irq_status_q[BIT_UNDERRUN],
                                               set_underrun, rd_status);
    // Receive side
    irq_status_d[BIT_RX_HIGH]     = hdi_level_flag(level_status_mode_in,
                                                   irq_status_q[BIT_RX_HIGH],
                                                   rx_high, rd_status);
    irq_status_d[BIT_RX_END]      = hdi_sticky(irq_status_q[BIT_RX_END],
                                               set_rx_end, rd_status);
    irq_status_d[BIT_RX_OVERFLOW] = hdi_sticky(irq_status_q[BIT_RX_OVERFLOW],
                                               set_overflow, rd_status);
    irq_status_d[BIT_RX_IDLE]     = hdi_sticky(irq_status_q[BIT_RX_IDLE],
                                               set_idle, rd_status);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask register and interrupt gating
  //
  // The pin is a latch, not an OR of flags:
  // it falls once and waits for a status read.

  // Whole byte written, including the bad checksum control
  assign irq_mask_d = wr_mask ? bus.wdata : irq_mask_q;

  // Framing-only enables drop out without framing
  wire [NUM_EVENTS-1:0] mode_gate = framed ? {NUM_EVENTS{1'b1}} : ~FRAMED_ONLY;
  wire [NUM_EVENTS-1:0] eff_en    = irq_mask_q[NUM_EVENTS-1:0] & mode_gate;

  // Flags are recorded regardless; only the pin sees the mask
  wire                  pending   = |(irq_status_q & eff_en);

  // Pin latches on; further events leave it alone until the read
  assign irq_active_d = rd_status ? 1'b0 :
                        irq_active_q ? 1'b1 :
                        pending;

  ////////////////////////////////////////////////////////////////////////////
  // Read data; the reserved top bit of status reads as zero
  //
  // Bit 7 is tied low; writes to it are lost.

  wire [DATA_W-1:0] status_rd = {RESERVED_RD, irq_status_q};
  // Snapshot held between reads
  wire [DATA_W-1:0] rdata_d   = rd_status ? status_rd :
                                rd_mask   ? irq_mask_q :
                                rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  //
  // All state shares one clock and enable.

  // Enables and test bit clear on reset so nothing interrupts early
  // Bit 7 feeds the checksum test output
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_mask_q <= MASK_RST;
    end else if (ce_in) begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // Event flags and the edge history for the raw-mode empty event
  // Reset leaves only the low-fill flag set,
  // since an empty FIFO is at its threshold
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_status_q <= STATUS_RST;
      tx_empty_q   <= 1'b1;
    end else if (ce_in) begin
      irq_status_q <= irq_status_d;
      tx_empty_q   <= tx_empty;
    end
  end

  // Interrupt latch
  // Cleared at read start, not read end,
  // so the pin rises with the snapshot
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_active_q <= 1'b0;
    end else if (ce_in) begin
      irq_active_q <= irq_active_d;
    end
  end

  // Read data is snapshotted at the read start so it stays stable on the pins
  // Unmapped reads leave the driver off
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
      oe_q    <= 1'b0;
    end else if (ce_in) begin
      rdata_q <= rdata_d;
      if (bus.rd_start) begin
        oe_q <= hit_mask | hit_status;
      end else if (bus.rd_end) begin
        oe_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  //
  // Every output comes from a flop.

  // Other addresses belong to other register blocks; bus left undriven
  assign data_out          = rdata_q;
  assign data_oe_out       = oe_q;
  // Active low pin from the latch
  assign irq_n_out         = ~irq_active_q;
  // Engine must not send data until the underrun flag is read away
  assign tx_hold_out       = irq_status_q[BIT_UNDERRUN];
  assign force_bad_fcs_out = irq_mask_q[BIT_BAD_FCS];

  // Limitation: a read of an unmapped index
  // leaves data_oe_out low; another block
  // must answer it on the shared bus.

endmodule
`default_nettype wire

// ---- src/hdi_pkg.sv ----
// Shared constants and helper functions for the HDLC interrupt mask and status block
`default_nettype none
package hdi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths and register indices
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned FILL_W          = 7;
  localparam logic [3:0]  REG_MASK_ADDR   = 4'he;
  localparam logic [3:0]  REG_STATUS_ADDR = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions shared by the mask and status registers
  localparam int unsigned NUM_EVENTS      = 7;
  localparam int unsigned BIT_TX_DONE     = 0;
  localparam int unsigned BIT_TX_LOW      = 1;
  localparam int unsigned BIT_UNDERRUN    = 2;
  localparam int unsigned BIT_RX_HIGH     = 3;
  localparam int unsigned BIT_RX_END      = 4;
  localparam int unsigned BIT_RX_OVERFLOW = 5;
  localparam int unsigned BIT_RX_IDLE     = 6;
  localparam int unsigned BIT_BAD_FCS     = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and mode-dependent masks
  localparam logic [7:0]  MASK_RST        = 8'h00;
  localparam logic [6:0]  STATUS_RST      = 7'h02;
  localparam logic [6:0]  FRAMED_ONLY     = 7'h54;
  localparam logic [0:0]  RESERVED_RD     = 1'h0;
  localparam logic [6:0]  FILL_EMPTY      = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Idle detection
  localparam int unsigned IDLE_CNT_W      = 4;
  localparam logic [3:0]  IDLE_ONES       = 4'hf;

  // Event flag: a set in the clearing cycle wins
  function automatic logic hdi_sticky(input logic q, input logic set, input logic clr);
    return set | (q & ~clr);
  endfunction

  // Level flag: live condition in level mode, sticky otherwise
  function automatic logic hdi_level_flag(input logic live, input logic q,
                                          input logic cond, input logic clr);
    return live ? cond : hdi_sticky(q, cond, clr);
  endfunction

endpackage
`default_nettype wire

// ---- verification/hdi_cpu_model.sv ----
// Behavioural 8-bit processor driving the register pins
`timescale 1ns/1ps
`default_nettype none
module hdi_cpu_model
  import hdi_pkg::*;
(
  // Clock and read-back
  input  wire logic              ref_clk_in,
  input  wire logic [DATA_W-1:0] rdata_in,
  input  wire logic              oe_in,
  // Bus pins toward the block
  output logic                   cs_n_out,
  output logic                   rd_n_out,
  output logic                   wr_n_out,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] wdata_out
);
  // Idle bus at time zero
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 4'h0;
    wdata_out = 8'h5a;
  end

  // Strobe held six cycles and idle four, above the three the synchroniser needs
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                        output logic oe);
    @(posedge ref_clk_in);
    #1;
    cs_n_out = 1'b0;
    addr_out = a;
    wdata_out = (a == REG_STATUS_ADDR) ? {1'b0, d[6:0]} : d;
    if (wr) begin
      wr_n_out = 1'b0;
    end else begin
      rd_n_out = 1'b0;
    end
    repeat (6) @(posedge ref_clk_in);
    q = rdata_in;
    oe = oe_in;
    #1;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    // Released pins drift so stale values cannot pass
    wdata_out = ~wdata_out;
    addr_out = ~addr_out;
    repeat (4) @(posedge ref_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- verification/hdi_irq_mask_status_props.sv ----
// Port-level assertions for the interrupt mask and status block
`timescale 1ns/1ps
`default_nettype none
module hdi_irq_mask_status_props
  import hdi_pkg::*;
(
  // Clock, reset, enable
  input wire logic              ref_clk_in,
  input wire logic              rst_n_in,
  input wire logic              ce_in,
  // Processor pins
  input wire logic              cs_n_in,
  input wire logic              rd_n_in,
  input wire logic              wr_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_out,
  // Modes, events, outputs
  input wire logic              no_framing_mode_in,
  input wire logic              underrun_abort_in,
  input wire logic              irq_n_out,
  input wire logic              tx_hold_out,
  input wire logic              force_bad_fcs_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  ////////////////////////////////////////////////////////////////////////////
  // Pins pass a two-stage synchroniser, so read effects lag by 2 to 5 edges
  abort_hold_a: assert property (
    ce_in && underrun_abort_in && !no_framing_mode_in |=> tx_hold_out)
    else $error("no hold after underrun abort");
  nofr_hold_a: assert property (
    ce_in && no_framing_mode_in && !tx_hold_out |=> !tx_hold_out)
    else $error("hold raised without framing");
  hold_read_a: assert property (
    $fell(tx_hold_out) |-> !$past(rd_n_in, 2) || !$past(rd_n_in, 3)
    || !$past(rd_n_in, 4) || !$past(rd_n_in, 5))
    else $error("hold dropped without a read");
  irq_stays_a: assert property (
    $rose(irq_n_out) |-> !$past(rd_n_in, 2) || !$past(rd_n_in, 3)
    || !$past(rd_n_in, 4) || !$past(rd_n_in, 5))
    else $error("interrupt released without a read");
  read_drop_a: assert property (
    ce_in && $fell(rd_n_in) && !cs_n_in && addr_in == REG_STATUS_ADDR
    && !irq_n_out |-> ##[1:6] irq_n_out)
    else $error("status read left interrupt asserted");
  oe_read_a: assert property (
    data_oe_out |-> !$past(rd_n_in, 2) || !$past(rd_n_in, 3)
    || !$past(rd_n_in, 4) || !$past(rd_n_in, 5))
    else $error("data driven outside a read");
  status_msb_a: assert property (
    $rose(data_oe_out) && $past(addr_in, 3) == REG_STATUS_ADDR |-> data_out[7] == 1'b0)
    else $error("reserved status bit read as one");
  fcs_write_a: assert property (
    $changed(force_bad_fcs_out) |-> !$past(wr_n_in, 3)
    || !$past(wr_n_in, 4) || !$past(wr_n_in, 5) || !$past(wr_n_in, 6))
    else $error("bad checksum control moved without a write");

  // Main scenarios reached
  irq_seen_c: cover property ($fell(irq_n_out));
  hold_seen_c: cover property ($rose(tx_hold_out));
  fcs_seen_c: cover property ($rose(force_bad_fcs_out));
endmodule

bind hdi_irq_mask_status hdi_irq_mask_status_props u_props (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .cs_n_in(cs_n_in),
  .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .addr_in(addr_in), .data_out(data_out),
  .data_oe_out(data_oe_out), .no_framing_mode_in(no_framing_mode_in),
  .underrun_abort_in(underrun_abort_in), .irq_n_out(irq_n_out),
  .tx_hold_out(tx_hold_out), .force_bad_fcs_out(force_bad_fcs_out));
`default_nettype wire

// ---- verification/tb_hdi_irq_mask_status.sv ----
// Self-checking bench for the interrupt mask and status block
`timescale 1ns/1ps
`default_nettype none
module tb_hdi_irq_mask_status;
  import hdi_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cs_n, rd_n, wr_n, oe, irq_n, hold, bad_fcs;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              lvl = 1'b0, nofr = 1'b0, txrst = 1'b0, rxv = 1'b0, rxb = 1'b0;
  logic [3:0]        ev = 4'h0;
  logic [FILL_W-1:0] txf = 7'h0a, txe = 7'h04, rxf = 7'h00, rxl = 7'h08;
  int                fails = 0, total_checks = 0, cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  always #10 clk = ~clk;

  hdi_irq_mask_status dut (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata), .data_out(rdata),
    .data_oe_out(oe), .level_status_mode_in(lvl), .no_framing_mode_in(nofr),
    .tx_reset_cmd_in(txrst), .tx_frame_end_in(ev[0]), .underrun_abort_in(ev[1]),
    .tx_fill_in(txf), .tx_empty_level_in(txe), .rx_frame_end_in(ev[2]),
    .rx_overflow_in(ev[3]), .rx_fill_in(rxf), .rx_full_level_in(rxl), .rx_bit_valid_in(rxv),
    .rx_bit_in(rxb), .irq_n_out(irq_n), .tx_hold_out(hold), .force_bad_fcs_out(bad_fcs));
  hdi_cpu_model cpu (.ref_clk_in(clk), .rdata_in(rdata), .oe_in(oe), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    logic       o;
    cpu.access(1'b0, a, 8'h00, q, o);
    chk(q, exp, what);
    chk({7'h0, o}, 8'h01, "read driven");
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       o;
    cpu.access(1'b1, a, d, q, o);
  endtask
  // One-cycle event pulses; step waits one edge
  task automatic pulse(input logic [3:0] m);
    @(posedge clk); #1; ev = m;
    @(posedge clk); #1; ev = 4'h0;
  endtask
  task automatic step;
    @(posedge clk); #1;
  endtask
  task automatic ones(input int n);
    for (int i = 0; i <= n; i++) begin
      step; rxv = 1'b1; rxb = (i < n);
      step; rxv = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk({7'h0, irq_n}, 8'h01, "irq idle");
    chk({7'h0, bad_fcs}, 8'h00, "fcs idle");
    rdchk(REG_MASK_ADDR, 8'h00, "mask reset");
    rdchk(REG_STATUS_ADDR, 8'h02, "status reset");
    rdchk(REG_STATUS_ADDR, 8'h00, "status cleared");
  endtask
  task automatic t_record;
    pulse(4'hf);
    step;
    chk({7'h0, hold}, 8'h01, "hold set");
    chk({7'h0, irq_n}, 8'h01, "masked irq");
    rdchk(REG_STATUS_ADDR, 8'h35, "framed events");
    chk({7'h0, hold}, 8'h00, "hold cleared");
    rdchk(REG_STATUS_ADDR, 8'h00, "events cleared");
  endtask
  task automatic t_irq;
    wr(REG_MASK_ADDR, 8'h20);
    pulse(4'h8);
    step;
    chk({7'h0, irq_n}, 8'h00, "irq active");
    pulse(4'h4);
    chk({7'h0, irq_n}, 8'h00, "irq still active");
    rdchk(REG_STATUS_ADDR, 8'h30, "both recorded");
    chk({7'h0, irq_n}, 8'h01, "irq released");
    pulse(4'h8);
    step;
    chk({7'h0, irq_n}, 8'h00, "irq again");
    rdchk(REG_STATUS_ADDR, 8'h20, "overflow again");
    wr(REG_MASK_ADDR, 8'h00);
  endtask
  task automatic t_noframe;
    nofr = 1'b1;
    wr(REG_MASK_ADDR, 8'h54);
    txf = 7'h00;
    step;
    txf = 7'h0a;
    pulse(4'h6);
    step;
    chk({7'h0, irq_n}, 8'h01, "enables ignored");
    chk({7'h0, hold}, 8'h00, "no underrun hold");
    rdchk(REG_STATUS_ADDR, 8'h03, "empty sets done");
    txrst = 1'b1;
    step;
    txrst = 1'b0;
    rdchk(REG_STATUS_ADDR, 8'h01, "reset sets done");
    wr(REG_MASK_ADDR, 8'h00);
    nofr = 1'b0;
  endtask
  task automatic t_level;
    lvl = 1'b1;
    txf = 7'h03;
    rxf = 7'h08;
    rdchk(REG_STATUS_ADDR, 8'h0a, "live levels");
    rdchk(REG_STATUS_ADDR, 8'h0a, "read keeps live");
    txf = 7'h0a;
    rxf = 7'h07;
    rdchk(REG_STATUS_ADDR, 8'h00, "live cleared");
    lvl = 1'b0;
    rxf = 7'h08;
    step;
    rxf = 7'h00;
    rdchk(REG_STATUS_ADDR, 8'h08, "sticky high");
    rdchk(REG_STATUS_ADDR, 8'h00, "sticky cleared");
  endtask
  task automatic t_idle;
    ones(14);
    rdchk(REG_STATUS_ADDR, 8'h00, "fourteen ones");
    ones(15);
    rdchk(REG_STATUS_ADDR, 8'h40, "fifteen ones");
  endtask
  task automatic t_regs;
    logic [7:0] q;
    logic       o;
    wr(REG_MASK_ADDR, 8'h80);
    chk({7'h0, bad_fcs}, 8'h01, "fcs forced");
    wr(REG_STATUS_ADDR, 8'h7f);
    wr(4'h3, 8'hff);
    cpu.access(1'b0, 4'h3, 8'h00, q, o);
    chk({7'h0, o}, 8'h00, "unmapped silent");
    rdchk(REG_STATUS_ADDR, 8'h00, "status write ignored");
    rdchk(REG_MASK_ADDR, 8'h80, "mask kept");
    wr(REG_MASK_ADDR, 8'h00);
    chk({7'h0, bad_fcs}, 8'h00, "fcs normal");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic conclude;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude;
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_record;
    t_irq;
    t_noframe;
    t_level;
    t_idle;
    t_regs;
    conclude;
  end
endmodule
`default_nettype wire
